// [rtl/dtspm_pin_mux.sv]
// Purpose: Function select for trace, boot, serial 1, debug and IRQ A pins.
// Assumes: Core side signals are on clk; pins and reset pin are asynchronous.
// Notes:   Pin outputs are registered, so they lag their sources by a cycle.
`timescale 1ns/1ps
module dtspm_pin_mux (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Debugger clock pin 32 and external reset pin
  input  wire logic        jtagClockIn,
  input  wire logic        externalReset_n,
  // Configuration
  input  wire logic [15:0] portAHighConfig,
  input  wire logic [15:0] portBLowConfig,
  input  wire logic [15:0] portCLowConfig,
  input  wire logic [7:0]  debugPinConfig,
  input  wire logic [1:0]  serial1ModeSelect,
  input  wire logic        serial1SpiSlave,
  input  wire logic        traceEnable,
  input  wire logic        traceSync4Wire,
  input  wire logic        traceAsync,
  input  wire logic        packetTraceEnable,
  // Function sources
  input  wire logic        tracePacketData,
  input  wire logic        tracePacketFrame,
  input  wire logic        cpuTraceBit3,
  input  wire logic        cpuTraceClkOut,
  input  wire logic        serial1SlaveOut,
  input  wire logic        serial1UartTx,
  input  wire logic        swoTrace,
  input  wire logic        jtagDataOut,
  input  wire logic        jtagDataOutEn,
  input  wire logic        swdioOut,
  input  wire logic        swdioOutEn,
  // GPIO drive, bit order A4 A5 B0 B1 B2 C2 C3 C4 from 0
  input  wire logic [7:0]  gpioOut,
  input  wire logic [7:0]  gpioOutEn,
  // Pad inputs, same bit order
  input  wire logic [7:0]  padIn,
  // Pad drive
  output logic [7:0]       padOut_ff,
  output logic [7:0]       padOutEn_ff,
  // Pad pulls
  output logic             clkPullDown_ff,
  output logic             jtagDataInPullUp_ff,
  output logic             modeSelPullUp_ff,
  output logic             dataOutPullUp_ff,
  // Function inputs to the core
  output logic [7:0]       gpioIn_ff,
  output logic             extIrqA_ff,
  output logic             serial1SlaveIn_ff,
  output logic             serial1UartRx_ff,
  output logic             jtagDataIn_ff,
  output logic             jtagModeSelect_ff,
  output logic             swdioIn_ff,
  // Debug mode and boot
  output logic             swdMode_ff,
  output logic             bootMonitorSelect_ff,
  output logic             bootStart_ff
);
  localparam int A4 = 0;
  localparam int A5 = 1;
  localparam int B0 = 2;
  localparam int B1 = 3;
  localparam int B2 = 4;
  localparam int C2 = 5;
  localparam int C3 = 6;
  localparam int C4 = 7;

  logic [7:0] padSync;
  logic       extRstSync_n;
  logic       bootSelSync_n;
  logic       swdLink;
  logic       swdSync;
  logic       linkRst_n;
  logic       extRstPrev_ff;
  logic       bootCapture_ff;
  logic [7:0] nxt_padOut;
  logic [7:0] nxt_padOutEn;
  logic       gpioDbg;
  logic       fldA4;
  logic       fldA5;
  logic       fldB0;
  logic       fldB1;
  logic       fldC2;
  logic       spiSlave;
  logic       uartMode;
  logic       swoActive;

  // Link domain reset from power-up or reset pin
  assign linkRst_n = arst_n & externalReset_n;

  // Debug mode tracker on the debugger clock
  dtspm_swd_switch u_swd (
    .linkClk    (jtagClockIn),
    .linkRst_n  (linkRst_n),
    .tmsIn      (padIn[C4]),
    .swdMode_ff (swdLink)
  );

  // Pads and mode into the system domain
  dtspm_sync #(
    .WIDTH   (11),
    .RST_VAL (11'h003)
  ) u_sync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn ({swdLink, padIn, externalReset_n, padIn[A5]}),
    .syncOut ({swdSync, padSync, extRstSync_n, bootSelSync_n})
  );

  // Field decode
  assign gpioDbg   = debugPinConfig[dtspm_pkg::DBG_GPIO_BIT];
  assign fldA4     = portAHighConfig[dtspm_pkg::PORT_A_PIN4_LO +: 4] == dtspm_pkg::CFG_ALT_OUT;
  assign fldA5     = portAHighConfig[dtspm_pkg::PORT_A_PIN5_LO +: 4] == dtspm_pkg::CFG_ALT_OUT;
  assign fldB0     = portBLowConfig[dtspm_pkg::PORT_B_PIN0_LO +: 4] == dtspm_pkg::CFG_ALT_OUT;
  assign fldB1     = portBLowConfig[dtspm_pkg::PORT_B_PIN1_LO +: 4] == dtspm_pkg::CFG_ALT_OUT;
  assign fldC2     = portCLowConfig[dtspm_pkg::PORT_C_PIN2_LO +: 4] == dtspm_pkg::CFG_ALT_OUT;
  assign spiSlave  = serial1ModeSelect == dtspm_pkg::SER_MODE_SPI && serial1SpiSlave;
  assign uartMode  = serial1ModeSelect == dtspm_pkg::SER_MODE_UART;
  assign swoActive = traceAsync && traceEnable && swdSync && fldC2;

  // Output function select per pad
  always_comb
  begin
    nxt_padOut   = gpioOut;
    nxt_padOutEn = gpioOutEn;
    // Port A pin 4: packet trace frame
    if (!traceEnable && packetTraceEnable && fldA4)
    begin
      nxt_padOut[A4]   = tracePacketFrame;
      nxt_padOutEn[A4] = 1'b1;
    end
    // Port A pin 5: packet data, else trace bit 3
    if (!traceEnable && packetTraceEnable && fldA5)
    begin
      nxt_padOut[A5]   = tracePacketData;
      nxt_padOutEn[A5] = 1'b1;
    end
    else if (traceEnable && traceSync4Wire && fldA5)
    begin
      nxt_padOut[A5]   = cpuTraceBit3;
      nxt_padOutEn[A5] = 1'b1;
    end
    // Port B pin 0: trace clock
    if (traceEnable && fldB0)
    begin
      nxt_padOut[B0]   = cpuTraceClkOut;
      nxt_padOutEn[B0] = 1'b1;
    end
    // Port B pin 1: SPI slave out or UART transmit
    if (fldB1 && spiSlave)
    begin
      nxt_padOut[B1]   = serial1SlaveOut;
      nxt_padOutEn[B1] = 1'b1;
    end
    else if (fldB1 && uartMode)
    begin
      nxt_padOut[B1]   = serial1UartTx;
      nxt_padOutEn[B1] = 1'b1;
    end
    // Port C pin 2: SWO first, then JTAG data out, then off in Serial Wire, GPIO only once freed
    if (swoActive)
    begin
      nxt_padOut[C2]   = swoTrace;
      nxt_padOutEn[C2] = 1'b1;
    end
    else if (!gpioDbg && !swdSync)
    begin
      nxt_padOut[C2]   = jtagDataOut;
      nxt_padOutEn[C2] = jtagDataOutEn;
    end
    else if (!gpioDbg)
    begin
      nxt_padOut[C2]   = 1'b0;
      nxt_padOutEn[C2] = 1'b0;
    end
    // Port C pin 3: JTAG data in unless freed or in Serial Wire, then GPIO
    if (!gpioDbg && !swdSync)
    begin
      nxt_padOut[C3]   = 1'b0;
      nxt_padOutEn[C3] = 1'b0;
    end
    // Port C pin 4: mode select input or SWDIO
    if (!gpioDbg && swdSync)
    begin
      nxt_padOut[C4]   = swdioOut;
      nxt_padOutEn[C4] = swdioOutEn;
    end
    else if (!gpioDbg)
    begin
      nxt_padOut[C4]   = 1'b0;
      nxt_padOutEn[C4] = 1'b0;
    end
  end

  // Registered pad drive
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      padOut_ff   <= 8'h00;
      padOutEn_ff <= 8'h00;
    end
    else
    begin
      padOut_ff   <= nxt_padOut;
      padOutEn_ff <= nxt_padOutEn;
    end
  end

  // Data pin pulls follow debug port ownership; clock pull-down is on in JTAG mode only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clkPullDown_ff      <= 1'b1;
      jtagDataInPullUp_ff <= 1'b1;
      modeSelPullUp_ff    <= 1'b1;
      dataOutPullUp_ff    <= 1'b1;
    end
    else
    begin
      clkPullDown_ff      <= !swdSync;
      jtagDataInPullUp_ff <= !gpioDbg && !swdSync;
      modeSelPullUp_ff    <= !gpioDbg;
      dataOutPullUp_ff    <= !gpioDbg || swoActive;
    end
  end

  // Input routing to GPIO and core functions
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gpioIn_ff         <= 8'h00;
      extIrqA_ff        <= 1'b0;
      serial1SlaveIn_ff <= 1'b0;
      serial1UartRx_ff  <= 1'b1;
      jtagDataIn_ff     <= 1'b1;
      jtagModeSelect_ff <= 1'b1;
      swdioIn_ff        <= 1'b1;
    end
    else
    begin
      gpioIn_ff         <= padSync;
      extIrqA_ff        <= padSync[B0];
      serial1SlaveIn_ff <= spiSlave ? padSync[B2] : 1'b0;
      serial1UartRx_ff  <= uartMode ? padSync[B2] : 1'b1;
      jtagDataIn_ff     <= (!gpioDbg && !swdSync) ? padSync[C3] : 1'b1;
      jtagModeSelect_ff <= (!gpioDbg && !swdSync) ? padSync[C4] : 1'b1;
      swdioIn_ff        <= (!gpioDbg && swdSync) ? padSync[C4] : 1'b1;
    end
  end

  // Debug mode seen by the system side
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      swdMode_ff <= 1'b0;
    else
      swdMode_ff <= swdSync && extRstSync_n;
  end

  // Boot select caught during reset and at its release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      extRstPrev_ff        <= 1'b0;
      bootCapture_ff       <= 1'b0;
      bootMonitorSelect_ff <= 1'b0;
      bootStart_ff         <= 1'b0;
    end
    else
    begin
      extRstPrev_ff <= extRstSync_n;
      bootStart_ff  <= extRstSync_n && !extRstPrev_ff;
      if (!extRstSync_n)
        bootCapture_ff <= bootCapture_ff || !bootSelSync_n;
      else if (bootStart_ff)
        bootCapture_ff <= 1'b0;
      if (extRstSync_n && !extRstPrev_ff)
        bootMonitorSelect_ff <= bootCapture_ff || !bootSelSync_n;
    end
  end

  // Checks
  a_pa5_packet_data: assert property (@(posedge clk) disable iff (!arst_n)
    (!traceEnable && packetTraceEnable && fldA5) |=> (padOutEn_ff[A5] && padOut_ff[A5] == $past(tracePacketData)))
    else $error("pin A5 does not carry packet data");

  a_pa5_trace_bit3: assert property (@(posedge clk) disable iff (!arst_n)
    (traceEnable && traceSync4Wire && fldA5) |=> (padOutEn_ff[A5] && padOut_ff[A5] == $past(cpuTraceBit3)))
    else $error("pin A5 does not carry trace bit 3");

  a_pa4_frame_out: assert property (@(posedge clk) disable iff (!arst_n)
    (!traceEnable && packetTraceEnable && fldA4) |=> (padOutEn_ff[A4] && padOut_ff[A4] == $past(tracePacketFrame)))
    else $error("pin A4 does not carry packet frame");

  a_pb1_serial_out: assert property (@(posedge clk) disable iff (!arst_n)
    (fldB1 && spiSlave) |=> (padOutEn_ff[B1] && padOut_ff[B1] == $past(serial1SlaveOut)))
    else $error("pin B1 does not carry slave data");

  a_pb1_uart_tx: assert property (@(posedge clk) disable iff (!arst_n)
    (fldB1 && uartMode) |=> (padOutEn_ff[B1] && padOut_ff[B1] == $past(serial1UartTx)))
    else $error("pin B1 does not carry UART transmit");

  a_uart_rx_route: assert property (@(posedge clk) disable iff (!arst_n)
    uartMode |=> (serial1UartRx_ff == $past(padSync[B2])))
    else $error("UART receive does not follow pin B2");

  a_pb0_trace_clk: assert property (@(posedge clk) disable iff (!arst_n)
    (traceEnable && fldB0) |=> (padOutEn_ff[B0] && padOut_ff[B0] == $past(cpuTraceClkOut)))
    else $error("pin B0 does not carry trace clock");

  a_irq_follows_pad: assert property (@(posedge clk) disable iff (!arst_n)
    arst_n |-> ##3 (extIrqA_ff == $past(padIn[B0], 3)))
    else $error("IRQ A does not follow pin B0");

  a_c2_swo_wins: assert property (@(posedge clk) disable iff (!arst_n)
    swoActive |=> (padOutEn_ff[C2] && padOut_ff[C2] == $past(swoTrace)))
    else $error("pin C2 does not carry SWO");

  a_c2_jtag_out: assert property (@(posedge clk) disable iff (!arst_n)
    (!gpioDbg && !swdSync && !swoActive) |=> (padOutEn_ff[C2] == $past(jtagDataOutEn)))
    else $error("pin C2 enable does not follow JTAG data out");

  a_c3_gpio_free: assert property (@(posedge clk) disable iff (!arst_n)
    (gpioDbg || swdSync) |=> (padOutEn_ff[C3] == $past(gpioOutEn[C3])))
    else $error("pin C3 not released to GPIO");

  a_swd_reset_jtag: assert property (@(posedge clk) disable iff (!arst_n)
    !extRstSync_n |=> !swdMode_ff)
    else $error("Serial Wire mode held through external reset");

  a_boot_select_rel: assert property (@(posedge clk) disable iff (!arst_n)
    (extRstSync_n && !extRstPrev_ff && !bootSelSync_n) |=> (bootMonitorSelect_ff && bootStart_ff))
    else $error("boot monitor not selected at reset release");

  a_pull_jtag_clk: assert property (@(posedge clk) disable iff (!arst_n)
    !swdSync |=> clkPullDown_ff)
    else $error("JTAG clock pull-down missing");

  c_swd_entered: cover property (@(posedge clk) disable iff (!arst_n) $rose(swdMode_ff));
  c_swo_driven: cover property (@(posedge clk) disable iff (!arst_n) swoActive);
  c_boot_monitor: cover property (@(posedge clk) disable iff (!arst_n) $rose(bootMonitorSelect_ff));
  c_uart_tx_pin: cover property (@(posedge clk) disable iff (!arst_n) fldB1 && uartMode);
endmodule

// [rtl/dtspm_pkg.sv]
// Purpose: Shared constants for the debug, trace and serial pin mux.
// Assumes: Config fields arrive as plain ports from the GPIO block.
// Notes:   Codes of the alternate output field and serial mode are local.
package dtspm_pkg;
  // Alternate output code of a 4-bit pin config field
  localparam logic [3:0]  CFG_ALT_OUT      = 4'h9;
  // Field positions (low bit) inside the config words
  localparam int          PORT_A_PIN4_LO   = 0;
  localparam int          PORT_A_PIN5_LO   = 4;
  localparam int          PORT_B_PIN0_LO   = 0;
  localparam int          PORT_B_PIN1_LO   = 4;
  localparam int          PORT_C_PIN2_LO   = 8;
  localparam int          DBG_GPIO_BIT     = 5;
  // Serial controller 1 mode codes
  localparam logic [1:0]  SER_MODE_UART    = 2'h1;
  localparam logic [1:0]  SER_MODE_SPI     = 2'h2;
  // Debug port switch sequences, sent LSB first on SWDIO/TMS
  localparam logic [15:0] SWD_SELECT_CODE  = 16'hE79E;
  localparam logic [15:0] JTAG_SELECT_CODE = 16'hE73C;
  localparam logic [5:0]  LINE_RESET_MIN   = 6'h32;
  // Synchroniser depth
  localparam int          SYNC_STAGES      = 2;
endpackage

// [rtl/dtspm_sync.sv]
// Purpose: Multi-bit level synchroniser, one chain per bit.
// Assumes: Each bit is an independent level.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module dtspm_sync #(
  parameter int             WIDTH    = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;

  // Refuse an empty chain at elaboration
  if (WIDTH < 1)
  begin : gBadWidth
    $error("dtspm_sync: WIDTH must be at least 1");
  end

  // Two flop chain
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1_ff <= RST_VAL;
      syncOut   <= RST_VAL;
    end
    else
    begin
      stage1_ff <= asyncIn;
      syncOut   <= stage1_ff;
    end
  end
endmodule

// [rtl/dtspm_swd_switch.sv]
// Purpose: Debug port mode tracker on the debugger clock.
// Assumes: Mode select line sampled on rising debugger clock.
// Notes:   Reset forces JTAG even while the debugger clock is stopped.
`timescale 1ns/1ps
module dtspm_swd_switch (
  // Link clock and reset
  input  wire logic linkClk,
  input  wire logic linkRst_n,
  // Mode select / SWDIO level
  input  wire logic tmsIn,
  // Mode, high for Serial Wire
  output logic      swdMode_ff
);
  logic [5:0]  highRun_ff;
  logic [15:0] shift_ff;
  logic [15:0] qual_ff;
  logic [15:0] nxt_shift;
  logic        runOk;

  assign runOk     = (highRun_ff >= dtspm_pkg::LINE_RESET_MIN);
  assign nxt_shift = {tmsIn, shift_ff[15:1]};

  // Run of high bits, saturating
  always_ff @(posedge linkClk or negedge linkRst_n)
  begin
    if (!linkRst_n)
      highRun_ff <= 6'h00;
    else if (!tmsIn)
      highRun_ff <= 6'h00;
    else if (highRun_ff != 6'h3F)
      highRun_ff <= highRun_ff + 6'h01;
  end

  // Code window and line reset history
  always_ff @(posedge linkClk or negedge linkRst_n)
  begin
    if (!linkRst_n)
    begin
      shift_ff <= 16'h0000;
      qual_ff  <= 16'h0000;
    end
    else
    begin
      shift_ff <= nxt_shift;
      qual_ff  <= {qual_ff[14:0], runOk};
    end
  end

  // Mode change on a code after a line reset
  always_ff @(posedge linkClk or negedge linkRst_n)
  begin
    if (!linkRst_n)
      swdMode_ff <= 1'b0;
    else if (qual_ff[14] && nxt_shift == dtspm_pkg::SWD_SELECT_CODE)
      swdMode_ff <= 1'b1;
    else if (qual_ff[14] && nxt_shift == dtspm_pkg::JTAG_SELECT_CODE)
      swdMode_ff <= 1'b0;
  end
endmodule

// [verif/dtspm_debug_model.sv]
// Purpose: Debugger model on pin 32 and the mode select / SWDIO line.
// Assumes: Line has a pull-up; clock pin has a pull-down and rests low.
// Notes:   Clock only runs inside a switch frame; data moves on falling edges.
`timescale 1ns/1ps
module dtspm_debug_model #(
  parameter int HALF_NS = 24
) (
  // Debugger clock pin
  output logic swclk,
  // Mode select / SWDIO drive
  output logic tmsOut,
  output logic tmsOe
);
  // Idle: clock still, line released
  initial
  begin
    swclk = 1'b0;
    tmsOut = 1'b1;
    tmsOe = 1'b0;
  end

  // Line reset of highs, then the code LSB first
  task automatic sendCode(input logic [15:0] code, input int highs);
    for (int i = 0; i < highs + 16; i++)
    begin
      tmsOe = 1'b1;
      tmsOut = (i < highs) ? 1'b1 : code[i - highs];
      #HALF_NS swclk = 1'b1;
      #HALF_NS swclk = 1'b0;
    end
    tmsOe = 1'b0;  // Released, pull-up takes the line
    tmsOut = ~tmsOut;
  endtask
endmodule

// [verif/testbench.sv]
// Purpose: Self-checking bench for the debug, trace and serial pin mux.
// Assumes: Registered outputs; pad inputs need sync plus one register.
// Notes:   Settling waits cover the pad loop back through the design.
`timescale 1ns/1ps
module testbench;
  logic        clk, arst_n, externalReset_n;
  logic [15:0] portAHighConfig, portBLowConfig, portCLowConfig;
  logic [7:0]  debugPinConfig, gpioOut, gpioOutEn, padOut_ff, padOutEn_ff, gpioIn_ff;
  logic [1:0]  serial1ModeSelect;
  logic        serial1SpiSlave, traceEnable, traceSync4Wire, traceAsync, packetTraceEnable;
  logic        tracePacketData, tracePacketFrame, cpuTraceBit3, cpuTraceClkOut;
  logic        serial1SlaveOut, serial1UartTx, swoTrace;
  logic        jtagDataOut, jtagDataOutEn, swdioOut, swdioOutEn;
  logic        clkPullDown_ff, jtagDataInPullUp_ff, modeSelPullUp_ff, dataOutPullUp_ff;
  logic        extIrqA_ff, serial1SlaveIn_ff, serial1UartRx_ff, jtagDataIn_ff;
  logic        jtagModeSelect_ff, swdioIn_ff, swdMode_ff, bootMonitorSelect_ff, bootStart_ff;
  logic        jtagClockIn, tmsOut, tmsOe;
  logic [6:0]  padLow;
  logic [7:0]  padIn;
  int          nErrors, samplesChecked;

  // C4 wire level: design, then debugger, else pull-up
  assign padIn = {padOutEn_ff[7] ? padOut_ff[7] : (tmsOe ? tmsOut : 1'b1), padLow};

  dtspm_pin_mux i_dtspm_pin_mux (
    .clk(clk), .arst_n(arst_n), .jtagClockIn(jtagClockIn), .externalReset_n(externalReset_n),
    .portAHighConfig(portAHighConfig), .portBLowConfig(portBLowConfig), .portCLowConfig(portCLowConfig),
    .debugPinConfig(debugPinConfig), .serial1ModeSelect(serial1ModeSelect), .serial1SpiSlave(serial1SpiSlave),
    .traceEnable(traceEnable), .traceSync4Wire(traceSync4Wire), .traceAsync(traceAsync),
    .packetTraceEnable(packetTraceEnable), .tracePacketData(tracePacketData),
    .tracePacketFrame(tracePacketFrame), .cpuTraceBit3(cpuTraceBit3), .cpuTraceClkOut(cpuTraceClkOut),
    .serial1SlaveOut(serial1SlaveOut), .serial1UartTx(serial1UartTx), .swoTrace(swoTrace),
    .jtagDataOut(jtagDataOut), .jtagDataOutEn(jtagDataOutEn), .swdioOut(swdioOut), .swdioOutEn(swdioOutEn),
    .gpioOut(gpioOut), .gpioOutEn(gpioOutEn), .padIn(padIn), .padOut_ff(padOut_ff), .padOutEn_ff(padOutEn_ff),
    .clkPullDown_ff(clkPullDown_ff), .jtagDataInPullUp_ff(jtagDataInPullUp_ff),
    .modeSelPullUp_ff(modeSelPullUp_ff), .dataOutPullUp_ff(dataOutPullUp_ff), .gpioIn_ff(gpioIn_ff),
    .extIrqA_ff(extIrqA_ff), .serial1SlaveIn_ff(serial1SlaveIn_ff), .serial1UartRx_ff(serial1UartRx_ff),
    .jtagDataIn_ff(jtagDataIn_ff), .jtagModeSelect_ff(jtagModeSelect_ff), .swdioIn_ff(swdioIn_ff),
    .swdMode_ff(swdMode_ff), .bootMonitorSelect_ff(bootMonitorSelect_ff), .bootStart_ff(bootStart_ff)
  );
  dtspm_debug_model i_dtspm_debug_model (.swclk(jtagClockIn), .tmsOut(tmsOut), .tmsOe(tmsOe));

  // System clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Compare helper
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samplesChecked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Let a change pass through the registered loop
  task settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  task completeRun();
    $display("errors %0d checks %0d", nErrors, samplesChecked);
    if (nErrors == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #400000;
    nErrors++;
    completeRun();
  end

  // Main sequence
  initial
  begin
    nErrors = 0; samplesChecked = 0;
    arst_n = 1'b0; externalReset_n = 1'b1;
    portAHighConfig = 16'h0000; portBLowConfig = 16'h0000; portCLowConfig = 16'h0000;
    debugPinConfig = 8'h00; serial1ModeSelect = 2'h0; serial1SpiSlave = 1'b0;
    {traceEnable, traceSync4Wire, traceAsync, packetTraceEnable} = 4'h0;
    {tracePacketData, tracePacketFrame, cpuTraceBit3, cpuTraceClkOut} = 4'h0;
    {serial1SlaveOut, serial1UartTx, swoTrace} = 3'h0;
    {jtagDataOut, jtagDataOutEn, swdioOut, swdioOutEn} = 4'h0;
    gpioOut = 8'h00; gpioOutEn = 8'h00; padLow = 7'h7F;
    repeat (4) @(posedge clk);
    #1;
    chk(padOutEn_ff, 8'h00, "reset drive");
    chk({4'h0, clkPullDown_ff, jtagDataInPullUp_ff, modeSelPullUp_ff, dataOutPullUp_ff}, 8'h0F, "pulls");
    chk({7'h0, swdMode_ff}, 8'h00, "jtag at power-up");
    @(posedge clk) arst_n <= 1'b1;
    // Packet trace on A4 and A5
    @(posedge clk);
    packetTraceEnable <= 1'b1; portAHighConfig <= 16'h0099; tracePacketData <= 1'b1;
    settle();
    chk({padOutEn_ff[1:0], padOut_ff[1:0]}, 8'h0E, "packet data");
    tracePacketData <= 1'b0; tracePacketFrame <= 1'b1;
    settle();
    chk({padOutEn_ff[1:0], padOut_ff[1:0]}, 8'h0D, "packet frame");
    // Core trace on blocks packet trace; 4-wire gives bit 3
    traceEnable <= 1'b1;
    settle();
    chk({6'h0, padOutEn_ff[1:0]}, 8'h00, "packet off in trace");
    traceSync4Wire <= 1'b1; cpuTraceBit3 <= 1'b1; portBLowConfig <= 16'h0099; cpuTraceClkOut <= 1'b1;
    settle();
    chk({padOutEn_ff[2:1], padOut_ff[2:1]}, 8'h0F, "trace bit3 and clock");
    traceEnable <= 1'b0; packetTraceEnable <= 1'b0;
    settle();
    chk({6'h0, padOutEn_ff[2:1]}, 8'h00, "trace off");
    // Serial 1 on B1 and B2, IRQ A on B0
    serial1ModeSelect <= dtspm_pkg::SER_MODE_SPI; serial1SpiSlave <= 1'b1;
    serial1SlaveOut <= 1'b1; padLow <= 7'h6B;
    settle();
    chk({padOutEn_ff[3], padOut_ff[3], serial1SlaveIn_ff, extIrqA_ff, gpioIn_ff[2]}, 8'h18, "spi slave");
    serial1ModeSelect <= dtspm_pkg::SER_MODE_UART; serial1UartTx <= 1'b0; padLow <= 7'h7F;
    settle();
    chk({padOutEn_ff[3], padOut_ff[3], serial1UartRx_ff, extIrqA_ff}, 8'h0B, "uart");
    padLow <= 7'h6F;
    settle();
    chk({7'h0, serial1UartRx_ff}, 8'h00, "uart rx low");
    // JTAG pins; GPIO may not take them
    padLow <= 7'h3F; jtagDataOutEn <= 1'b1; gpioOutEn <= 8'hE0; gpioOut <= 8'hE0;
    settle();
    chk({padOutEn_ff[7:5], padOut_ff[5], jtagDataIn_ff, jtagModeSelect_ff}, 8'h09, "jtag pins");
    // Switch to Serial Wire
    i_dtspm_debug_model.sendCode(dtspm_pkg::SWD_SELECT_CODE, 52);
    settle();
    chk({7'h0, swdMode_ff}, 8'h01, "serial wire mode");
    swdioOutEn <= 1'b1; swdioOut <= 1'b0; gpioOut <= 8'hC0;
    settle();
    chk({padOutEn_ff[7:6], padOut_ff[7:6], swdioIn_ff}, 8'h1A, "swdio and c3 gpio");
    traceEnable <= 1'b1; traceAsync <= 1'b1; traceSync4Wire <= 1'b0; portCLowConfig <= 16'h0900; swoTrace <= 1'b1;
    settle();
    chk({6'h0, padOutEn_ff[5], padOut_ff[5]}, 8'h03, "swo");
    traceAsync <= 1'b0; debugPinConfig <= 8'h20; gpioOut <= 8'hA0;
    settle();
    chk({padOutEn_ff[7:5], padOut_ff[7:5]}, 8'h3D, "gpio release");
    chk({4'h0, clkPullDown_ff, jtagDataInPullUp_ff, modeSelPullUp_ff, dataOutPullUp_ff}, 8'h00, "pulls off");
    debugPinConfig <= 8'h00; gpioOutEn <= 8'h00; swdioOutEn <= 1'b0;
    // External reset, boot select low then high
    for (int k = 0; k < 2; k++)
    begin
      padLow[1] <= (k == 1);
      externalReset_n <= 1'b0;
      settle();
      chk({7'h0, swdMode_ff}, 8'h00, "jtag after reset");
      externalReset_n <= 1'b1;
      for (int n = 0; n < 20 && bootStart_ff !== 1'b1; n++)
      begin
        @(posedge clk);
        #1;
      end
      chk({6'h0, bootStart_ff, bootMonitorSelect_ff}, {6'h0, 1'b1, k == 0}, "boot select");
      @(posedge clk);
      padLow[1] <= 1'b1;
      if (k == 0)
        i_dtspm_debug_model.sendCode(dtspm_pkg::SWD_SELECT_CODE, 52);
      settle();
    end
    completeRun();
  end
endmodule
